//--- src/sfs_pkg.sv
// Purpose: shared constants for the solenoid fault supervisor
// Assumes: 100 MHz clock, 32-bit register bus
// Notes: times are kept in ns; cycle counts derive from them
package sfs_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  // blanking, low-side configuration
  localparam int unsigned BLANK_LS_LONG_MIN_NS = 5060000;
  localparam int unsigned BLANK_LS_LONG_MAX_NS = 7440000;
  localparam int unsigned BLANK_LS_SHORT_MIN_NS = 2530000;
  localparam int unsigned BLANK_LS_SHORT_MAX_NS = 3750000;
  // blanking, high-side configuration
  localparam int unsigned BLANK_HS_LONG_MIN_NS = 1000000;
  localparam int unsigned BLANK_HS_LONG_MAX_NS = 1500000;
  localparam int unsigned BLANK_HS_SHORT_MIN_NS = 500000;
  localparam int unsigned BLANK_HS_SHORT_MAX_NS = 750000;
  // least off time the controller should keep for valid diagnostics
  localparam int unsigned MIN_OFF_LS_LONG_NS = 7520000;
  localparam int unsigned MIN_OFF_HS_LONG_NS = 1580000;
  localparam int unsigned MIN_OFF_LS_SHORT_NS = 3830000;
  localparam int unsigned MIN_OFF_HS_SHORT_NS = 830000;
  localparam int unsigned BLANK_W = 20;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_DRV_EN = 8'h00;
  localparam logic [7:0] OFS_SETPOINT = 8'h04;
  localparam logic [7:0] OFS_EXCEPT = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // driver_enable_reg fields
  localparam int unsigned DRV_W = 6;
  localparam int unsigned DRV_ENABLE = 0;
  localparam int unsigned DRV_SW_MODE = 1;
  localparam int unsigned DRV_OVC_RETRY = 2;
  localparam int unsigned DRV_BLANK_SEL = 3;
  localparam int unsigned DRV_HIGH_SIDE = 4;
  localparam int unsigned DRV_DIAG_EN = 5;
  localparam logic [DRV_W-1:0] DRV_RESET = 6'h00;

  // exceptions register fields
  localparam int unsigned EXC_W = 16;
  localparam int unsigned EXC_OT_SHUT = 0;
  localparam int unsigned EXC_LS_OVC = 1;
  localparam int unsigned EXC_HS_OVC = 2;
  localparam int unsigned EXC_CLAMP = 3;
  localparam int unsigned EXC_STG = 5;
  localparam int unsigned EXC_OPEN = 6;
  localparam int unsigned EXC_OT_WARN = 15;
  localparam logic [EXC_W-1:0] EXC_HARD_MASK = 16'h000F;
  localparam logic [EXC_W-1:0] EXC_RESET = 16'h0000;

  // current set-point
  localparam int unsigned SP_W = 11;
  localparam logic [SP_W-1:0] SP_RESET = 11'h000;

  // status register fields
  localparam int unsigned STS_ON = 0;
  localparam int unsigned STS_HOLD = 1;
  localparam int unsigned STS_BLANK_DONE = 2;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // merge write data into a register under byte strobes
  function automatic logic [31:0] sfs_strb_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] strb
  );
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage

//--- src/sfs_blank_timer.sv
// Purpose: off-state blanking interval timer
// Assumes: run drops whenever the channel leaves the off state
// Notes: done stays high until run drops
`timescale 1ns/1ns
module sfs_blank_timer import sfs_pkg::*; #(
  parameter int unsigned W = BLANK_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic [W-1:0] limit,
  output logic done
);

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  logic [W-1:0] cnt_q, cnt_d;
  logic done_q, done_d;

  always_comb begin
    cnt_d = cnt_q;
    done_d = done_q;
    if (!run) begin
      cnt_d = '0;
      done_d = 1'b0;
    end else if (!done_q) begin
      if (cnt_q + W'(1) >= limit) begin
        done_d = 1'b1;
      end
      cnt_d = cnt_q + W'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end

  assign done = done_q;

endmodule // sfs_blank_timer

//--- src/sfs_axil_slave.sv
// Purpose: AXI4-Lite slave front end, one write and one read at a time
// Assumes: register side answers combinationally
// Notes: reg_wr and reg_rd are one-cycle strobes
`timescale 1ns/1ns
module sfs_axil_slave import sfs_pkg::*; #(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic reg_wr,
  output logic [ADDR_W-1:0] reg_waddr,
  output logic [31:0] reg_wdata,
  output logic [3:0] reg_wstrb,
  input wire logic reg_werr,
  output logic reg_rd,
  output logic [ADDR_W-1:0] reg_raddr,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rerr
);

  // ---------------------------------------------------------------
  // write channel
  // ---------------------------------------------------------------
  logic aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic awready_q, awready_d, wready_q, wready_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;

  always_comb begin
    reg_wr = aw_full_q & w_full_q & ~bvalid_q;
    aw_full_d = aw_full_q;
    w_full_d = w_full_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (awvalid && awready_q) begin
      aw_full_d = 1'b1;
      awaddr_d = awaddr;
    end
    if (wvalid && wready_q) begin
      w_full_d = 1'b1;
      wdata_d = wdata;
      wstrb_d = wstrb;
    end
    if (reg_wr) begin
      aw_full_d = 1'b0;
      w_full_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = reg_werr ? RESP_SLVERR : RESP_OKAY;
    end else if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    awready_d = ~aw_full_d;
    wready_d = ~w_full_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
    end
  end

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  logic ar_full_q, ar_full_d, arready_q, arready_d;
  logic [ADDR_W-1:0] araddr_q, araddr_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;

  always_comb begin
    reg_rd = ar_full_q & ~rvalid_q;
    ar_full_d = ar_full_q;
    araddr_d = araddr_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (arvalid && arready_q) begin
      ar_full_d = 1'b1;
      araddr_d = araddr;
    end
    if (reg_rd) begin
      ar_full_d = 1'b0;
      rvalid_d = 1'b1;
      rdata_d = reg_rdata;
      rresp_d = reg_rerr ? RESP_SLVERR : RESP_OKAY;
    end else if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
    arready_d = ~ar_full_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_full_q <= 1'b0;
      arready_q <= 1'b1;
      araddr_q <= '0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else begin
      ar_full_q <= ar_full_d;
      arready_q <= arready_d;
      araddr_q <= araddr_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign reg_waddr = awaddr_q;
  assign reg_wdata = wdata_q;
  assign reg_wstrb = wstrb_q;
  assign reg_raddr = araddr_q;

endmodule // sfs_axil_slave

//--- src/sfs_supervisor.sv
// Purpose: fault supervision for one current-controlled solenoid channel
// Assumes: all channel inputs synchronous to aclk, fault inputs filtered
// Notes: one instance per channel; registers reached over AXI4-Lite
`timescale 1ns/1ns
// Notes on behaviour
// - low side: blank off-state diagnostics 5.06-7.44 ms, or 2.53-3.75 ms
// - high side: blank off-state diagnostics 1-1.5 ms, or 500-750 us
// - high-side overcurrent in PWM: tristate, zero set-point, flag bit 2
// - low-side overcurrent with high side on: tristate, zero, flag bit 1
// - software mode with retry: only latch, resume at next PWM rising edge
// - clamp active while on: tristate, flag bit 3
// - short to ground while off with diagnostics: flag bit 5
// - open load while off with diagnostics: flag bit 6
// - overtemperature warning while on: flag bit 15
// - overtemperature shutdown while on: tristate, zero, flag bit 0
// - flags clear on read; host clears fault then re-enables channel
module sfs_supervisor import sfs_pkg::*; #(
  parameter int unsigned ADDR_W = 8,
  parameter int unsigned BLANK_LS_LONG_CYC =
    (BLANK_LS_LONG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
  parameter int unsigned BLANK_LS_SHORT_CYC =
    (BLANK_LS_SHORT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
  parameter int unsigned BLANK_HS_LONG_CYC =
    (BLANK_HS_LONG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
  parameter int unsigned BLANK_HS_SHORT_CYC =
    (BLANK_HS_SHORT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pwm_in,
  input wire logic pwm_mode_in,
  input wire logic full_on_in,
  input wire logic hs_on_in,
  input wire logic hs_ovc_in,
  input wire logic ls_ovc_in,
  input wire logic clamp_in,
  input wire logic ot_warn_in,
  input wire logic ot_shut_in,
  input wire logic stg_in,
  input wire logic open_in,
  output logic chan_on,
  output logic chan_tristate,
  output logic [SP_W-1:0] setpoint_out,
  output logic diag_eval,
  output logic irq
);

  // ---------------------------------------------------------------
  // bus front end
  // ---------------------------------------------------------------
  logic reg_wr, reg_rd, reg_werr, reg_rerr;
  logic [ADDR_W-1:0] reg_waddr, reg_raddr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [3:0] reg_wstrb;

  sfs_axil_slave #(
    .ADDR_W(ADDR_W)
  ) u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .reg_wr(reg_wr),
    .reg_waddr(reg_waddr),
    .reg_wdata(reg_wdata),
    .reg_wstrb(reg_wstrb),
    .reg_werr(reg_werr),
    .reg_rd(reg_rd),
    .reg_raddr(reg_raddr),
    .reg_rdata(reg_rdata),
    .reg_rerr(reg_rerr)
  );

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [DRV_W-1:0] drv_q, drv_d;
  logic [SP_W-1:0] sp_q, sp_d;
  logic [EXC_W-1:0] exc_q, exc_d, ist_q, ist_d, imask_q, imask_d;
  logic hold_q, hold_d, pwm_prev_q;
  logic chan_on_q, tri_q, diag_q, irq_q;
  logic [SP_W-1:0] sp_out_q;

  logic on_state, blank_run, blank_done, diag_ok, pwm_rise;
  logic hs_ev, ls_ev, ovc_ev, retry, ovc_trip, trip, zero_sp;
  logic [EXC_W-1:0] ev_set, exc_rd_clr, ist_w1c;
  logic [BLANK_W-1:0] blank_limit;
  logic [31:0] wr_drv, wr_sp, wr_ist, wr_imask;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] ofs);
    return a == ADDR_W'(ofs);
  endfunction

  // ---------------------------------------------------------------
  // channel condition and fault events
  // ---------------------------------------------------------------
  always_comb begin
    on_state = drv_q[DRV_ENABLE] & ~hold_q & pwm_in;
    pwm_rise = pwm_in & ~pwm_prev_q;
    hs_ev = hs_ovc_in & pwm_mode_in & on_state;
    ls_ev = ls_ovc_in & (pwm_mode_in | full_on_in) & hs_on_in
            & on_state;
    ovc_ev = hs_ev | ls_ev;
    retry = drv_q[DRV_SW_MODE] & drv_q[DRV_OVC_RETRY];
    ovc_trip = ovc_ev & ~retry;
    trip = ovc_trip | (clamp_in & on_state)
           | (ot_shut_in & on_state);
    zero_sp = ovc_trip | (ot_shut_in & on_state);
    blank_run = ~on_state & drv_q[DRV_DIAG_EN];
    diag_ok = blank_run & blank_done;
    ev_set = '0;
    ev_set[EXC_HS_OVC] = hs_ev;
    ev_set[EXC_LS_OVC] = ls_ev;
    ev_set[EXC_CLAMP] = clamp_in & on_state;
    ev_set[EXC_STG] = stg_in & diag_ok;
    ev_set[EXC_OPEN] = open_in & diag_ok;
    ev_set[EXC_OT_WARN] = ot_warn_in & on_state;
    ev_set[EXC_OT_SHUT] = ot_shut_in & on_state;
  end

  // ---------------------------------------------------------------
  // blanking interval select
  // ---------------------------------------------------------------
  always_comb begin
    case ({drv_q[DRV_HIGH_SIDE], drv_q[DRV_BLANK_SEL]})
      2'h0: blank_limit = BLANK_W'(BLANK_LS_LONG_CYC);
      2'h1: blank_limit = BLANK_W'(BLANK_LS_SHORT_CYC);
      2'h2: blank_limit = BLANK_W'(BLANK_HS_LONG_CYC);
      2'h3: blank_limit = BLANK_W'(BLANK_HS_SHORT_CYC);
      default: blank_limit = BLANK_W'(BLANK_LS_LONG_CYC);
    endcase
  end

  sfs_blank_timer #(
    .W(BLANK_W)
  ) u_blank (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(blank_run),
    .limit(blank_limit),
    .done(blank_done)
  );

  // ---------------------------------------------------------------
  // register next values
  // ---------------------------------------------------------------
  always_comb begin
    wr_drv = sfs_strb_merge(32'(drv_q), reg_wdata, reg_wstrb);
    wr_sp = sfs_strb_merge(32'(sp_q), reg_wdata, reg_wstrb);
    wr_ist = sfs_strb_merge(32'h0, reg_wdata, reg_wstrb);
    wr_imask = sfs_strb_merge(32'(imask_q), reg_wdata, reg_wstrb);
    drv_d = drv_q;
    sp_d = sp_q;
    imask_d = imask_q;
    ist_w1c = '0;
    exc_rd_clr = '0;
    if (reg_wr && hit(reg_waddr, OFS_DRV_EN)) begin
      drv_d = wr_drv[DRV_W-1:0];
      // re-enable refused while a hard fault is still latched
      if ((exc_q & EXC_HARD_MASK) != '0) begin
        drv_d[DRV_ENABLE] = drv_q[DRV_ENABLE];
      end
    end
    if (reg_wr && hit(reg_waddr, OFS_SETPOINT)) begin
      sp_d = wr_sp[SP_W-1:0];
    end
    if (reg_wr && hit(reg_waddr, OFS_IRQ_STAT)) begin
      ist_w1c = wr_ist[EXC_W-1:0];
    end
    if (reg_wr && hit(reg_waddr, OFS_IRQ_MASK)) begin
      imask_d = wr_imask[EXC_W-1:0];
    end
    if (reg_rd && hit(reg_raddr, OFS_EXCEPT)) begin
      exc_rd_clr = '1;
    end
    // faults win over a same-cycle host write
    if (trip) begin
      drv_d[DRV_ENABLE] = 1'b0;
    end
    if (zero_sp) begin
      sp_d = '0;
    end
    // events set over a same-cycle clear; diagnostics never trip
    exc_d = (exc_q & ~exc_rd_clr) | ev_set;
    ist_d = (ist_q & ~ist_w1c) | ev_set;
    hold_d = hold_q;
    if (!drv_q[DRV_ENABLE] || pwm_rise) begin
      hold_d = 1'b0;
    end
    if (ovc_ev && retry) begin
      hold_d = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // read mux and decode errors
  // ---------------------------------------------------------------
  always_comb begin
    reg_rdata = 32'h0;
    reg_rerr = 1'b0;
    case (reg_raddr)
      ADDR_W'(OFS_DRV_EN): reg_rdata = 32'(drv_q);
      ADDR_W'(OFS_SETPOINT): reg_rdata = 32'(sp_q);
      ADDR_W'(OFS_EXCEPT): reg_rdata = 32'(exc_q);
      ADDR_W'(OFS_IRQ_STAT): reg_rdata = 32'(ist_q);
      ADDR_W'(OFS_IRQ_MASK): reg_rdata = 32'(imask_q);
      ADDR_W'(OFS_STATUS): begin
        reg_rdata[STS_ON] = chan_on_q;
        reg_rdata[STS_HOLD] = hold_q;
        reg_rdata[STS_BLANK_DONE] = blank_done;
      end
      default: reg_rerr = 1'b1;
    endcase
    reg_werr = !(hit(reg_waddr, OFS_DRV_EN) || hit(reg_waddr, OFS_SETPOINT)
                 || hit(reg_waddr, OFS_EXCEPT)
                 || hit(reg_waddr, OFS_IRQ_STAT)
                 || hit(reg_waddr, OFS_IRQ_MASK)
                 || hit(reg_waddr, OFS_STATUS));
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drv_q <= DRV_RESET;
      sp_q <= SP_RESET;
      exc_q <= EXC_RESET;
      ist_q <= EXC_RESET;
      imask_q <= EXC_RESET;
      hold_q <= 1'b0;
      pwm_prev_q <= 1'b0;
    end else begin
      drv_q <= drv_d;
      sp_q <= sp_d;
      exc_q <= exc_d;
      ist_q <= ist_d;
      imask_q <= imask_d;
      hold_q <= hold_d;
      pwm_prev_q <= pwm_in;
    end
  end

  // ---------------------------------------------------------------
  // output flops
  // ---------------------------------------------------------------
  logic chan_on_d, tri_d, diag_d, irq_d;
  logic [SP_W-1:0] sp_out_d;

  always_comb begin
    // a trip takes the channel off at the clock edge after the cycle it is seen
    chan_on_d = on_state & ~trip & ~(ovc_ev & retry);
    tri_d = ~chan_on_d;
    sp_out_d = sp_d;
    diag_d = diag_ok;
    irq_d = |(ist_d & imask_d);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan_on_q <= 1'b0;
      tri_q <= 1'b1;
      sp_out_q <= SP_RESET;
      diag_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      chan_on_q <= chan_on_d;
      tri_q <= tri_d;
      sp_out_q <= sp_out_d;
      diag_q <= diag_d;
      irq_q <= irq_d;
    end
  end

  assign chan_on = chan_on_q;
  assign chan_tristate = tri_q;
  assign setpoint_out = sp_out_q;
  assign diag_eval = diag_q;
  assign irq = irq_q;

endmodule // sfs_supervisor

//--- bench/sfs_properties.sv
// Purpose: port-level assertions for sfs_supervisor
// Assumes: one clock domain, synchronous reset
// Notes: attached by bind at the foot of this file
`timescale 1ns/1ns
module sfs_properties import sfs_pkg::*; #(
  parameter int unsigned BLANK_HS_SHORT_CYC = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic pwm_in,
  input wire logic pwm_mode_in,
  input wire logic hs_ovc_in,
  input wire logic ls_ovc_in,
  input wire logic clamp_in,
  input wire logic ot_warn_in,
  input wire logic ot_shut_in,
  input wire logic chan_on,
  input wire logic chan_tristate,
  input wire logic [SP_W-1:0] setpoint_out,
  input wire logic diag_eval,
  input wire logic irq
);
  // ---------------------------------------------------------------
  // off-time counter and checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  int unsigned off_q;
  int unsigned off_d;
  logic quiet;
  assign quiet = !(hs_ovc_in || ls_ovc_in || clamp_in || ot_shut_in);
  always_comb begin
    off_d = chan_on ? 0 : off_q + 1;
  end
  always_ff @(posedge aclk) begin
    off_q <= aresetn ? off_d : 0;
  end
  sequence s_off;
    !chan_on && chan_tristate;
  endsequence
  property p_reset;
    $rose(aresetn) |-> !chan_on && setpoint_out == 11'h000 && !irq;
  endproperty
  a_reset: assert property (p_reset)
    else $error("outputs not at reset values");
  property p_tri;
    chan_tristate != chan_on;
  endproperty
  a_tri: assert property (p_tri)
    else $error("tristate not the inverse of drive");
  property p_hs_ovc;
    chan_on && pwm_in && pwm_mode_in && hs_ovc_in |-> ##[1:2] s_off;
  endproperty
  a_hs_ovc: assert property (p_hs_ovc)
    else $error("overcurrent left channel driving");
  property p_clamp;
    chan_on && clamp_in |=> s_off;
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("clamp left channel driving");
  property p_shut;
    chan_on && pwm_in && ot_shut_in |=> s_off ##0 setpoint_out == 11'h000;
  endproperty
  a_shut: assert property (p_shut)
    else $error("shutdown left channel or set-point");
  property p_warn;
    chan_on && pwm_in && ot_warn_in && quiet |=> chan_on
      && $stable(setpoint_out);
  endproperty
  a_warn: assert property (p_warn)
    else $error("warning disturbed the channel");
  property p_blank;
    diag_eval && !chan_on |-> off_q + 1 >= BLANK_HS_SHORT_CYC;
  endproperty
  a_blank: assert property (p_blank)
    else $error("diagnostics evaluated inside blanking");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold)
    else $error("write response dropped early");
endmodule // sfs_properties

bind sfs_supervisor sfs_properties #(
  .BLANK_HS_SHORT_CYC(BLANK_HS_SHORT_CYC)
) u_props (.*);

//--- bench/sfs_load_model.sv
// Purpose: load-side model raising fault conditions on request
// Assumes: inj bits are one-cycle requests from the bench
// Notes: on-state faults only while driving, diagnostics only while off
`timescale 1ns/1ns
module sfs_load_model (
  input wire logic aclk,
  input wire logic chan_on,
  input wire logic [6:0] inj,
  output logic hs_ovc_in = 1'b0,
  output logic ls_ovc_in = 1'b0,
  output logic clamp_in = 1'b0,
  output logic ot_warn_in = 1'b0,
  output logic ot_shut_in = 1'b0,
  output logic stg_in = 1'b0,
  output logic open_in = 1'b0
);
  always @(posedge aclk) begin
    {ot_shut_in, ot_warn_in, clamp_in, ls_ovc_in, hs_ovc_in} <=
      chan_on ? inj[4:0] : 5'h00;
    {open_in, stg_in} <= chan_on ? 2'h0 : inj[6:5];
  end
endmodule // sfs_load_model

//--- bench/sfs_supervisor_tb.sv
// Purpose: register-level self-check of sfs_supervisor
// Assumes: blanking shortened to 20/10/8/4 cycles
// Notes: faults raised through sfs_load_model
`timescale 1ns/1ns
module sfs_supervisor_tb import sfs_pkg::*; ();
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, chan_on, chan_tristate, diag_eval, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, br, rr;
  logic pwm_in = 1'b0, pwm_mode_in = 1'b1;
  logic full_on_in = 1'b0, hs_on_in = 1'b1;
  logic hs_ovc_in, ls_ovc_in, clamp_in, ot_warn_in, ot_shut_in;
  logic stg_in, open_in;
  logic [6:0] inj = 7'h00;
  logic [SP_W-1:0] setpoint_out;
  int fail_count = 0, n_tests = 0, i, c;
  int eb[5] = '{2, 1, 3, 15, 0};
  int lim[4] = '{20, 10, 8, 4};
  always #5 aclk = ~aclk;
  sfs_supervisor #(.BLANK_LS_LONG_CYC(20), .BLANK_LS_SHORT_CYC(10),
    .BLANK_HS_LONG_CYC(8), .BLANK_HS_SHORT_CYC(4)) DUT (.*);
  sfs_load_model u_load (.*);
  // ---------------------------------------------------------------
  // bus and check tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic guard();
    if (c >= 50) begin
      fail_count++;
      results();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    c = 0;
    do begin
      @(posedge aclk);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
      c++;
    end while (!s_axi_bvalid && c < 50);
    br = s_axi_bresp;
    guard();
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    c = 0;
    do begin
      @(posedge aclk);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
      c++;
    end while (!s_axi_rvalid && c < 50);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    guard();
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(nm, rv, e);
  endtask
  task automatic hit(input logic [6:0] f);
    inj <= f;
    tick(1);
    inj <= 7'h00;
    tick(3);
  endtask
  initial begin
    tick(2);
    aresetn <= 1'b1;
    tick(1);
    rc("exc_reset", OFS_EXCEPT, 32'h0);
    pwm_in <= 1'b1;
    for (i = 0; i < 5; i++) begin
      {pwm_mode_in, full_on_in} <= (i == 1) ? 2'b01 : 2'b10;
      wr(OFS_SETPOINT, 32'h7FF);
      wr(OFS_DRV_EN, 32'h1);
      tick(2);
      chk("on", chan_on, 32'h1);
      hit(7'h01 << i);
      chk("on_after", chan_on, i == 3);
      chk("tri", chan_tristate, i != 3);
      chk("sp", setpoint_out, i inside {2, 3} ? 32'h7FF : 32'h0);
      wr(OFS_DRV_EN, 32'h1);
      rc("restart", OFS_DRV_EN, i == 3);
      rc("exc", OFS_EXCEPT, 32'h1 << eb[i]);
      rc("exc_clr", OFS_EXCEPT, 32'h0);
    end
    wr(OFS_DRV_EN, 32'h7);
    chk("wr_ok", br, RESP_OKAY);
    tick(2);
    hit(7'h01);
    chk("retry_hold", chan_on, 32'h0);
    rc("retry_drv", OFS_DRV_EN, 32'h7);
    rc("retry_sts", OFS_STATUS, 32'h2);
    pwm_in <= 1'b0;
    tick(2);
    pwm_in <= 1'b1;
    tick(3);
    chk("retry_resume", chan_on, 32'h1);
    rc("retry_exc", OFS_EXCEPT, 32'h4);
    wr(OFS_DRV_EN, 32'h0);
    for (i = 0; i < 4; i++) begin
      wr(OFS_DRV_EN, 32'h20 | (i << 3));
      c = 0;
      while (!diag_eval && c < 100) begin
        tick(1);
        c++;
      end
      chk("blank", c >= lim[i] && c <= lim[i] + 2, 32'h1);
      hit(i[0] ? 7'h40 : 7'h20);
      rc("diag_exc", OFS_EXCEPT, i[0] ? 32'h40 : 32'h20);
      wr(OFS_DRV_EN, 32'h0);
    end
    wr(OFS_DRV_EN, 32'h38);
    tick(8);
    wr(OFS_IRQ_STAT, 32'hFFFF);
    wr(OFS_IRQ_MASK, 32'h40);
    hit(7'h20);
    chk("irq_masked", irq, 32'h0);
    wr(OFS_IRQ_MASK, 32'h20);
    tick(2);
    chk("irq_set", irq, 32'h1);
    wr(OFS_IRQ_STAT, 32'h20);
    tick(2);
    chk("irq_clear", irq, 32'h0);
    rd(8'h20);
    chk("bad_rd", rr, RESP_SLVERR);
    wr(8'h24, 32'h0);
    chk("bad_wr", br, RESP_SLVERR);
    results();
  end
endmodule // sfs_supervisor_tb
